// ---- hdl/measurement_compensation_datapath.sv ----
// Compensation datapath: line frequency, frequency auto-calibration,
// temperature, input-capacitor and line-drop compensation, channel offsets.
// Assumes raw quantities and commands arrive synchronous to clk_i.
`timescale 1ns/100ps
`include "comp_consts.svh"

// Contract
// - Hold 16-bit line frequency; in DC mode force it to zero.
// - Frequency result only guaranteed between 45 and 65 Hz.
// - Successful frequency calibration rewrites frequency gain and acknowledges.
// - Frequency calibration in DC mode answers negative, changes nothing.
// - Scale frequency, current, powers by one plus coefficient times delta.
// - Six coefficients; above one when hotter, below one when colder.
// - Temperature is 10-bit thermistor code compared with stored reference.
// - Gain calibration captures present thermistor reading as reference.
// - AC mode only: add coef times frequency times voltage, shifted.
// - Always add drop coef times current RMS, shifted, to voltage.
// - Shift register upper byte sets drop shift, default 28.
// - Shift register lower byte sets capacitor shift, default 32.
// - 24-bit offset from high byte plus 16-bit value added to code.
module measurement_compensation_datapath (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dc_mode_i,
  input wire logic [15:0] freq_raw_i,
  input wire logic [31:0] irms_raw_i,
  input wire logic [31:0] vrms_raw_i,
  input wire logic signed [31:0] p_act_raw_i,
  input wire logic signed [31:0] p_react_raw_i,
  input wire logic [9:0] therm_i,
  input wire logic [23:0] adc_ch0_i,
  input wire logic [23:0] adc_ch1_i,
  input wire logic cal_freq_i,
  input wire logic cal_gain_i,
  input wire logic reg_wr_i,
  input wire comp_pkg::reg_idx_t reg_addr_i,
  input wire comp_pkg::word_t reg_wdata_i,
  output comp_pkg::word_t reg_rdata_o,
  output logic ack_o,
  output logic nak_o,
  output logic busy_o,
  output logic [15:0] line_freq_o,
  output logic [31:0] irms_o,
  output logic [31:0] vrms_o,
  output logic signed [31:0] p_act_o,
  output logic signed [31:0] p_react_o,
  output logic [23:0] ch0_code_o,
  output logic [23:0] ch1_code_o
);
  import comp_pkg::*;

  // Reset value of each register slot
  function automatic word_t reset_value(input reg_idx_t idx);
    word_t v;
    v = 16'h0000;
    unique case (idx)
      `IDX_FREQ_GAIN: v = `RST_FREQ_GAIN;
      `IDX_FREQ_REF: v = `RST_FREQ_REF;
      `IDX_SHIFTS: v = `RST_SHIFTS;
      `IDX_OFS_HIGH: v = `RST_OFS_HIGH;
      `IDX_OFS_CH0: v = `RST_OFS_CH0;
      `IDX_OFS_CH1: v = `RST_OFS_CH1;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : reset_value

  // x * (1 + c * dt / 2^M), product kept at full width before the shift
  function automatic logic signed [32:0] temp_comp(
    input logic signed [32:0] x,
    input word_t c,
    input logic signed [10:0] dt
  );
    logic signed [60:0] prod;
    logic signed [60:0] shifted;
    prod = x * $signed({1'b0, c}) * dt;
    shifted = prod >>> `TEMP_COEF_SHIFT;
    return x + shifted[32:0];
  endfunction : temp_comp

  word_t regs_q [16];
  cal_state_t state_q;
  logic [31:0] dividend_q;
  logic [15:0] divisor_q;
  logic [31:0] quot_q;
  logic [16:0] rem_q;
  logic [5:0] step_q;
  logic gain_wr;
  logic [15:0] freq_meas;
  logic [31:0] freq_scaled;
  logic signed [10:0] dtemp;
  logic hotter;
  logic signed [32:0] f_comp;
  logic signed [32:0] i_comp;
  logic signed [32:0] pa_comp;
  logic signed [32:0] pr_comp;
  logic [63:0] cap_prod;
  logic [63:0] cap_term;
  logic [47:0] drop_prod;
  logic [47:0] drop_term;
  logic [7:0] drop_shift;
  logic [7:0] cap_shift;
  logic [16:0] rem_try;
  logic [23:0] ofs_ch0;
  logic [23:0] ofs_ch1;

  // Raw frequency times gain; DC mode forces the result to zero
  assign freq_scaled = freq_raw_i * regs_q[`IDX_FREQ_GAIN];
  assign freq_meas = dc_mode_i ? 16'h0000 :
    freq_scaled[`FREQ_GAIN_SHIFT +: 16];

  // Temperature delta and coefficient choice
  assign dtemp = $signed({1'b0, therm_i}) -
    $signed({1'b0, regs_q[`IDX_TEMP_CAL][9:0]});
  assign hotter = dtemp > 11'sd0;

  // Temperature-compensated quantities, zero delta leaves them as is
  always_comb begin
    f_comp = temp_comp($signed({17'h00000, freq_meas}),
      hotter ? regs_q[`IDX_TC_FREQ_ABOVE] : regs_q[`IDX_TC_FREQ_BELOW],
      dtemp);
    i_comp = temp_comp($signed({1'b0, irms_raw_i}),
      hotter ? regs_q[`IDX_TC_CUR_ABOVE] : regs_q[`IDX_TC_CUR_BELOW],
      dtemp);
    pa_comp = temp_comp(33'(p_act_raw_i),
      hotter ? regs_q[`IDX_TC_POW_ABOVE] : regs_q[`IDX_TC_POW_BELOW],
      dtemp);
    pr_comp = temp_comp(33'(p_react_raw_i),
      hotter ? regs_q[`IDX_TC_POW_ABOVE] : regs_q[`IDX_TC_POW_BELOW],
      dtemp);
  end

  // Input-capacitor and line-drop terms, shifted after full products
  assign drop_shift = regs_q[`IDX_SHIFTS][`DROP_SHIFT_MSB:`DROP_SHIFT_LSB];
  assign cap_shift = regs_q[`IDX_SHIFTS][`CAP_SHIFT_MSB:`CAP_SHIFT_LSB];
  assign cap_prod = regs_q[`IDX_INCAP] * freq_meas * vrms_raw_i;
  assign cap_term = cap_prod >> cap_shift;
  assign drop_prod = regs_q[`IDX_LINE_DROP] * irms_raw_i;
  assign drop_term = drop_prod >> drop_shift;

  // 24-bit channel offsets from shared high bytes and 16-bit values
  assign ofs_ch0 = {regs_q[`IDX_OFS_HIGH][7:0], regs_q[`IDX_OFS_CH0]};
  assign ofs_ch1 = {regs_q[`IDX_OFS_HIGH][15:8], regs_q[`IDX_OFS_CH1]};

  // Registered results
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      line_freq_o <= 16'h0000;
      irms_o <= 32'h00000000;
      vrms_o <= 32'h00000000;
      p_act_o <= 32'sh00000000;
      p_react_o <= 32'sh00000000;
    end else begin
      line_freq_o <= dc_mode_i ? 16'h0000 : f_comp[15:0];
      irms_o <= dc_mode_i ? i_comp[31:0] :
        i_comp[31:0] + cap_term[31:0];
      vrms_o <= vrms_raw_i + drop_term[31:0];
      p_act_o <= pa_comp[31:0];
      p_react_o <= pr_comp[31:0];
    end
  end

  // Converter codes with offsets added, wrapping in 24 bits
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ch0_code_o <= 24'h000000;
      ch1_code_o <= 24'h000000;
    end else begin
      ch0_code_o <= adc_ch0_i + ofs_ch0;
      ch1_code_o <= adc_ch1_i + ofs_ch1;
    end
  end

  // One restoring division step
  assign rem_try = {rem_q[15:0], dividend_q[31]};

  // Frequency auto-calibration: gain * reference / measured
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      dividend_q <= 32'h00000000;
      divisor_q <= 16'h0000;
      quot_q <= 32'h00000000;
      rem_q <= 17'h00000;
      step_q <= 6'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cal_freq_i && !dc_mode_i) begin
            dividend_q <= regs_q[`IDX_FREQ_GAIN] * regs_q[`IDX_FREQ_REF];
            divisor_q <= f_comp[15:0];
            quot_q <= 32'h00000000;
            rem_q <= 17'h00000;
            step_q <= 6'd0;
            state_q <= ST_DIVIDE;
          end
        end
        ST_DIVIDE: begin
          dividend_q <= {dividend_q[30:0], 1'b0};
          if (rem_try >= {1'b0, divisor_q}) begin
            rem_q <= rem_try - {1'b0, divisor_q};
            quot_q <= {quot_q[30:0], 1'b1};
          end else begin
            rem_q <= rem_try;
            quot_q <= {quot_q[30:0], 1'b0};
          end
          step_q <= step_q + 6'd1;
          if (step_q == `DIV_STEPS - 6'd1) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Gain write-back only for a quotient that fits 16 bits
  assign gain_wr = (state_q == ST_FINISH) && (divisor_q != 16'h0000) &&
    (quot_q[31:16] == 16'h0000);
  assign busy_o = state_q != ST_IDLE;

  // Command replies, one-cycle pulses
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      nak_o <= 1'b0;
    end else begin
      ack_o <= gain_wr || (cal_gain_i && !busy_o);
      nak_o <= (cal_freq_i && dc_mode_i && !busy_o) ||
        ((state_q == ST_FINISH) && !gain_wr);
    end
  end

  // Register slots; hardware updates win over a host write
  generate
    for (genvar i = 0; i < 15; i++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          regs_q[i] <= reset_value(4'(i));
        end else if (gain_wr && i == `IDX_FREQ_GAIN) begin
          regs_q[i] <= quot_q[15:0];
        end else if (cal_gain_i && !busy_o && i == `IDX_TEMP_CAL) begin
          regs_q[i] <= {6'h00, therm_i};
        end else if (reg_wr_i && reg_addr_i == 4'(i)) begin
          regs_q[i] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // Read-only slot mirrors the line-frequency result
  assign regs_q[`IDX_LINE_FREQ] = line_freq_o;

  // Registered read data
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= regs_q[reg_addr_i];
    end
  end

endmodule : measurement_compensation_datapath

// ---- include/comp_consts.svh ----
// Constants of the compensation datapath: register indices, resets, shifts.
// Assumes inclusion by bare name from the design file.
`ifndef COMP_CONSTS_SVH
`define COMP_CONSTS_SVH
`define IDX_FREQ_GAIN 4'h0
`define IDX_FREQ_REF 4'h1
`define IDX_TEMP_CAL 4'h2
`define IDX_TC_FREQ_ABOVE 4'h3
`define IDX_TC_FREQ_BELOW 4'h4
`define IDX_TC_CUR_ABOVE 4'h5
`define IDX_TC_CUR_BELOW 4'h6
`define IDX_TC_POW_ABOVE 4'h7
`define IDX_TC_POW_BELOW 4'h8
`define IDX_LINE_DROP 4'h9
`define IDX_INCAP 4'hA
`define IDX_SHIFTS 4'hB
`define IDX_OFS_HIGH 4'hC
`define IDX_OFS_CH0 4'hD
`define IDX_OFS_CH1 4'hE
`define IDX_LINE_FREQ 4'hF
`define RST_FREQ_GAIN 16'h8000
`define RST_FREQ_REF 16'hC350
`define RST_SHIFTS 16'h1C20
`define RST_OFS_HIGH 16'hFFFF
`define RST_OFS_CH0 16'h7D80
`define RST_OFS_CH1 16'hEC00
`define DROP_SHIFT_MSB 15
`define DROP_SHIFT_LSB 8
`define CAP_SHIFT_MSB 7
`define CAP_SHIFT_LSB 0
`define TEMP_COEF_SHIFT 16
`define FREQ_GAIN_SHIFT 15
`define DIV_STEPS 6'd32
`endif

// ---- include/comp_pkg.sv ----
// Types shared by the compensation datapath and its bench.
// Assumes comp_consts.svh holds every number.
package comp_pkg;
  typedef logic [3:0] reg_idx_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_FINISH} cal_state_t;
endpackage : comp_pkg

// ---- tb/comp_asserts.sv ----
// Port checker of the compensation datapath.
// Assumes a bind onto measurement_compensation_datapath.
`timescale 1ns/100ps
module comp_asserts (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dc_mode_i,
  input wire logic cal_freq_i,
  input wire logic cal_gain_i,
  input wire logic reg_wr_i,
  input wire comp_pkg::reg_idx_t reg_addr_i,
  input wire comp_pkg::word_t reg_wdata_i,
  input wire comp_pkg::word_t reg_rdata_o,
  input wire logic ack_o,
  input wire logic nak_o,
  input wire logic busy_o,
  input wire logic [15:0] line_freq_o,
  input wire logic [31:0] irms_raw_i,
  input wire logic [31:0] vrms_raw_i,
  input wire logic [31:0] vrms_o
);
  import comp_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Frequency command taken while idle
  sequence s_take;
    !busy_o && cal_freq_i && !cal_gain_i;
  endsequence
  // Divider run, then one reply
  sequence s_divide;
    busy_o [*8] ##26 (ack_o || nak_o);
  endsequence
  a_dc_freq_zero: assert property (dc_mode_i |=> line_freq_o == 16'h0)
    else $error("line frequency not zero in DC");
  a_dc_cal_nak: assert property (s_take ##0 dc_mode_i |=> nak_o && !ack_o)
    else $error("no refusal in DC");
  a_ac_cal_time: assert property (s_take ##0 !dc_mode_i |=> s_divide)
    else $error("calibration reply late");
  a_gain_cal_ack: assert property (!busy_o && cal_gain_i |=> ack_o)
    else $error("gain capture not acknowledged");
  a_wr_readback: assert property (reg_wr_i && !busy_o && !cal_gain_i
    && reg_addr_i != 4'hF ##1 !reg_wr_i && !cal_gain_i && $stable(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("register readback wrong");
  a_reply_excl: assert property (!(ack_o && nak_o))
    else $error("ack and nak together");
  a_busy_quiet: assert property (busy_o |-> !ack_o && !nak_o)
    else $error("reply while busy");
  a_drop_zero: assert property (irms_raw_i == 32'h0
    |=> vrms_o == $past(vrms_raw_i))
    else $error("voltage changed with zero current");
endmodule : comp_asserts
bind measurement_compensation_datapath comp_asserts i_comp_asserts (
  .clk_i, .reset_n_i, .dc_mode_i, .cal_freq_i, .cal_gain_i, .reg_wr_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .ack_o, .nak_o, .busy_o,
  .line_freq_o, .irms_raw_i, .vrms_raw_i, .vrms_o);

// ---- tb/host_model.sv ----
// Host side model: issues calibration commands, collects the reply.
// Assumes the bench calls command() and keeps the reference stable.
`timescale 1ns/100ps
module host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic nak_i,
  output logic cal_freq_o,
  output logic cal_gain_o
);
  initial cal_freq_o = 1'b0;
  initial cal_gain_o = 1'b0;
  // One-cycle pulse, reply 1 ack, 2 nak, 0 none in 40 cycles
  task automatic command(input logic freq, output int reply);
    int n;
    n = 0;
    @(posedge clk_i);
    cal_freq_o <= freq;
    cal_gain_o <= !freq;
    @(posedge clk_i);
    cal_freq_o <= 1'b0;
    cal_gain_o <= 1'b0;
    // A DC refusal or a gain capture answers right after the taking edge
    #1;
    while (!ack_i && !nak_i && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    reply = ack_i ? 1 : (nak_i ? 2 : 0);
  endtask : command
endmodule : host_model

// ---- tb/testbench.sv ----
// Self-checking bench of the compensation datapath.
// Assumes host_model and comp_asserts are compiled first.
`timescale 1ns/100ps
module testbench;
  import comp_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, dc_mode_i = 1'b1;
  logic cal_freq_i, cal_gain_i, reg_wr_i = 1'b0;
  logic [15:0] freq_raw_i = 16'h0, line_freq_o;
  logic [31:0] irms_raw_i = 32'h0, vrms_raw_i = 32'h0, irms_o, vrms_o;
  logic signed [31:0] p_act_raw_i = 32'h0, p_react_raw_i = 32'h0;
  logic signed [31:0] p_act_o, p_react_o;
  logic [9:0] therm_i = 10'h155;
  logic [23:0] adc_ch0_i = 24'h0, adc_ch1_i = 24'h0, ch0_code_o, ch1_code_o;
  reg_idx_t reg_addr_i = 4'h0;
  word_t reg_wdata_i = 16'h0, reg_rdata_o;
  logic ack_o, nak_o, busy_o;
  int fails = 0, n_tests = 0, seed = 32'h15a94de3, r;
  int model [16] = '{16'h8000, 16'hC350, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    16'h1C20, 16'hFFFF, 16'h7D80, 16'hEC00, 0};
  always #5 clk_i = ~clk_i;
  measurement_compensation_datapath i_measurement_compensation_datapath (.*);
  host_model i_host_model (.clk_i, .ack_i(ack_o), .nak_i(nak_o),
    .cal_freq_o(cal_freq_i), .cal_gain_o(cal_gain_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input int a, input int d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a[3:0];
    reg_wdata_i <= d[15:0];
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    if (a != 15) model[a] = d & 32'hFFFF;
  endtask : wr
  task automatic rd(input int a);
    @(posedge clk_i);
    reg_addr_i <= a[3:0];
    repeat (2) @(posedge clk_i);
    #1 check(reg_rdata_o, model[a]);
  endtask : rd
  task automatic cmd(input logic f, input int exp);
    int rep;
    i_host_model.command(f, rep);
    check(rep, exp);
  endtask : cmd
  // Random traffic, outputs compared one cycle later
  task automatic run(input int n, input logic [15:0] lf,
    input logic [15:0] fm);
    repeat (n) begin
      @(posedge clk_i);
      irms_raw_i <= $random(seed);
      vrms_raw_i <= $random(seed);
      p_act_raw_i <= $random(seed);
      p_react_raw_i <= $random(seed);
      adc_ch0_i <= 24'($random(seed));
      adc_ch1_i <= 24'($random(seed));
      @(posedge clk_i);
      #1 check(line_freq_o, lf);
      check(irms_o, 32'(irms_raw_i + ((64'(model[10][15:0]) * fm
        * vrms_raw_i) >> model[11][7:0])));
      check(p_act_o, p_act_raw_i);
      check(p_react_o, p_react_raw_i);
      check(vrms_o, 32'(vrms_raw_i + ((longint'(model[9]) * irms_raw_i)
        >> model[11][15:8])));
      check(32'(ch0_code_o), 32'(24'(adc_ch0_i + {model[12][7:0],
        model[13][15:0]})));
      check(32'(ch1_code_o), 32'(24'(adc_ch1_i + {model[12][15:8],
        model[14][15:0]})));
    end
  endtask : run
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (r = 0; r < 15; r++) rd(r);
    cmd(1'b0, 1);
    model[2] = 16'h155;
    rd(2);
    cmd(1'b1, 2);
    rd(0);
    wr(9, $random(seed));
    wr(11, 16'h1810);
    wr(15, 16'h1234);
    rd(15);
    run(20, 16'h0, 16'h0);
    dc_mode_i <= 1'b0;
    freq_raw_i <= 16'h5000;
    wr(3, 16'h1000);
    wr(4, 16'h0800);
    wr(10, 16'h0100);
    therm_i <= 10'h165;
    run(4, 16'hA000, 16'h5000);
    therm_i <= 10'h145;
    run(4, 16'h2800, 16'h5000);
    therm_i <= 10'h155;
    freq_raw_i <= 16'hA000;
    cmd(1'b1, 1);
    model[0] = 16'h9C40;
    rd(0);
    freq_raw_i <= 16'h4000;
    cmd(1'b1, 2);
    rd(0);
    results();
  end
endmodule : testbench
